//--- pkg/timer_pwm_pkg.sv
// Constants and register map for the timer flag and PWM unit
package timer_pwm_pkg;
  localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h00; // Edge/mode control
  localparam logic [7:0] ADDR_ACC_CTRL    = 8'h04; // Accumulator control and count
  localparam logic [7:0] ADDR_MASK        = 8'h08; // Interrupt masks and counter clock
  localparam logic [7:0] ADDR_FLAGS       = 8'h0c; // Flags, write one to clear
  localparam logic [7:0] ADDR_FORCE_PWM   = 8'h10;
  localparam logic [7:0] ADDR_DUTY        = 8'h14; // Duty a [15:8], duty b [7:0]
  localparam logic [7:0] ADDR_PWM_COUNT   = 8'h18;
  localparam logic [7:0] ADDR_DUTY_BUF    = 8'h1c;
  localparam logic [7:0] ADDR_PRESCALER   = 8'h20;
  localparam logic [7:0] ADDR_MAIN_COUNT  = 8'h24;
  localparam logic [7:0] ADDR_COMPARE0    = 8'h28; // Five compares, one word each
  localparam logic [15:0] COMPARE_RESET   = 16'hffff;
  localparam int FLAG_SHARED = 15;
  localparam int FLAG_CMP_LO = 11;
  localparam int FLAG_CAP_LO = 8;
  localparam int FLAG_TOF    = 7;
  localparam int FLAG_ACC_OV = 5;
  localparam int FLAG_ACC_IN = 4;
  localparam logic [15:0] FLAG_MASK = 16'hffb0;
  localparam int ACC_GATE_DIV = 512;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- pkg/pwm_channel_if.sv
// Interface between the timer core and one PWM channel
`timescale 1ns/1ps
interface pwm_channel_if;
  logic       tick;
  logic [15:0] count;
  logic       slow_fast;
  logic [7:0] duty;
  logic [7:0] duty_buf;
  logic       wave;
  modport core (output tick, output count, output slow_fast, output duty, input duty_buf, input wave);
  modport chan (input tick, input count, input slow_fast, input duty, output duty_buf, output wave);
endinterface

//--- hw/pwm_channel.sv
// One PWM channel: duty buffer and waveform comparator
`timescale 1ns/1ps
module pwm_channel (
  input  wire logic  clock,
  input  wire logic  nrst,
  pwm_channel_if.chan ch
);
  typedef struct packed {
    logic [7:0] duty_buf;
    logic       wave;
  } chan_state_t;
  chan_state_t state;
  chan_state_t next_state;
  logic [7:0]  phase;
  logic        period_start;

  // Phase bits scaled to the period length
  assign phase        = ch.slow_fast ? ch.count[14:7] : ch.count[7:0];
  assign period_start = ch.slow_fast ? (ch.count[14:0] == 15'h0000) : (ch.count[7:0] == 8'h00);

  // Buffer load and compare
  always_comb begin
    next_state = state;
    if (ch.tick) begin
      if (period_start) begin
        next_state.duty_buf = ch.duty;
        next_state.wave     = 8'h00 < ch.duty;
      end else begin
        next_state.wave = phase < state.duty_buf;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ch.duty_buf = state.duty_buf;
  assign ch.wave     = state.wave;

  zero_duty_low_a: assert property (@(posedge clock) disable iff (!nrst)
    state.duty_buf == 8'h00 |-> !state.wave) else $error("zero duty not low");
  buffer_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !(ch.tick && period_start) |=> state.duty_buf == $past(state.duty_buf))
    else $error("duty buffer changed mid period");
endmodule // pwm_channel

//--- hw/timer_pwm_unit.sv
// Timer flags, compare force logic and two-channel PWM with AXI4-Lite registers
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module timer_pwm_unit (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [3:0]  capture_pins,
  input  wire logic        accumulator_input_pin,
  input  wire logic        ext_clock_pin,
  output logic [4:0]       compare_pins,
  output logic             channel_a_pwm_pin,
  output logic             channel_b_pwm_pin,
  output logic             timer_irq
);
  typedef struct packed {
    logic [15:0]  tctl;
    logic [15:0]  acc_ctl;
    logic [15:0]  mask;
    logic [15:0]  flags;
    logic [15:0]  pwm_control_register;
    logic [7:0]   duty_a;
    logic [7:0]   duty_b;
    logic [15:0]  main_cnt;
    logic [15:0]  pwm_cnt;
    logic [8:0]   presc;
    logic [9:0]   gate_cnt;
    logic [79:0]  compare;
    logic [4:0]   oc_out;
    logic [5:0]   pin_prev;
    logic         main_tick_q;
    logic         aw_done;
    logic         w_done;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } core_state_t;
  core_state_t  state;
  core_state_t  next_state;
  logic [5:0]   sync1;
  logic [5:0]   sync2;
  logic [5:0]   pins;
  logic         ext_rise;
  logic         main_tick;
  logic         pwm_tick;
  logic         acc_edge;
  logic         acc_tick;
  logic [3:0]   cap_hit;
  logic [4:0]   cmp_hit;
  logic [15:0]  set_flags;
  logic         wr_go;
  logic [15:0]  irq_src;
  pwm_channel_if ch_a ();
  pwm_channel_if ch_b ();

  // Tap of the prescaler: index n gives divide by 2^(n+1)
  function automatic logic tap(input logic [8:0] p, input logic [8:0] q, input int n);
    tap = p[n] & ~q[n];
  endfunction

  // Edge detect against a two-bit edge control
  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
    edge_hit = (sel[0] & now & ~prev) | (sel[1] & ~now & prev);
  endfunction

  // Compare pin action from a mode/level pair; channel 1 has no pair here
  function automatic logic oc_next(input logic [15:0] ctl, input int i, input logic cur);
    case ((i == 0) ? 2'b00 : ctl[6+2*i +: 2])
      2'b01:   oc_next = ~cur;
      2'b10:   oc_next = 1'b0;
      2'b11:   oc_next = 1'b1;
      default: oc_next = cur;
    endcase
  endfunction

  // Read value of one register word
  function automatic logic [31:0] read_word(input core_state_t s, input logic [7:0] a,
                                            input logic [7:0] ba, input logic [7:0] bb);
    read_word = 32'h0000_0000;
    case (a)
      timer_pwm_pkg::ADDR_TIMER_CTRL: read_word = {16'h0000, s.tctl};
      timer_pwm_pkg::ADDR_ACC_CTRL:   read_word = {16'h0000, s.acc_ctl};
      timer_pwm_pkg::ADDR_MASK:       read_word = {16'h0000, s.mask};
      timer_pwm_pkg::ADDR_FLAGS:      read_word = {16'h0000, s.flags};
      timer_pwm_pkg::ADDR_FORCE_PWM:  read_word = {16'h0000, 5'h00, s.pwm_control_register[10:0]};
      timer_pwm_pkg::ADDR_DUTY:       read_word = {16'h0000, s.duty_a, s.duty_b};
      timer_pwm_pkg::ADDR_PWM_COUNT:  read_word = {16'h0000, s.pwm_cnt};
      timer_pwm_pkg::ADDR_DUTY_BUF:   read_word = {16'h0000, ba, bb};
      timer_pwm_pkg::ADDR_PRESCALER:  read_word = {23'h000000, s.presc};
      timer_pwm_pkg::ADDR_MAIN_COUNT: read_word = {16'h0000, s.main_cnt};
      default: begin
        for (int i = 0; i < 5; i++) begin
          if (a == timer_pwm_pkg::ADDR_COMPARE0 + 8'(4 * i)) begin
            read_word = {16'h0000, s.compare[16*i +: 16]};
          end
        end
      end
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= timer_pwm_pkg::ADDR_COMPARE0 + 8'h10);
  endfunction

  // Two-flop synchroniser for every pin input
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {ext_clock_pin, accumulator_input_pin, capture_pins};
      sync2 <= sync1;
    end
  end
  assign pins     = sync2;
  assign ext_rise = pins[5] & ~state.pin_prev[5];

  // Counter clocks from the shared prescaler
  always_comb begin
    logic [8:0] np;
    np       = state.presc + 9'h001;
    main_tick = (state.mask[2:0] == 3'b111) ? ext_rise : tap(np, state.presc, int'(state.mask[2:0]) + 1);
    pwm_tick  = (state.pwm_control_register[6:4] == 3'b111) ? ext_rise : tap(np, state.presc, int'(state.pwm_control_register[6:4]));
  end

  assign ch_a.tick      = pwm_tick;
  assign ch_b.tick      = pwm_tick;
  assign ch_a.count     = state.pwm_cnt;
  assign ch_b.count     = state.pwm_cnt;
  assign ch_a.slow_fast = state.pwm_control_register[3];
  assign ch_b.slow_fast = state.pwm_control_register[2];
  assign ch_a.duty      = state.duty_a;
  assign ch_b.duty      = state.duty_b;

  pwm_channel u_chan_a (.clock(clock), .nrst(nrst), .ch(ch_a));
  pwm_channel u_chan_b (.clock(clock), .nrst(nrst), .ch(ch_b));

  // Event detection
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cap_hit[i] = edge_hit(state.tctl[2*i +: 2], pins[i], state.pin_prev[i]);
    end
    cap_hit[3] = state.acc_ctl[10] & edge_hit(state.tctl[7:6], pins[3], state.pin_prev[3]);
    for (int i = 0; i < 5; i++) begin
      cmp_hit[i] = main_tick && (state.main_cnt == state.compare[16*i +: 16]);
    end
    cmp_hit[4] = cmp_hit[4] & ~state.acc_ctl[10];
    acc_edge = state.acc_ctl[12] ? (pins[4] & ~state.pin_prev[4]) : (~pins[4] & state.pin_prev[4]);
    acc_tick = state.acc_ctl[13] ? ((pins[4] != state.acc_ctl[12]) && (state.gate_cnt == 10'h1ff))
                                 : acc_edge;
  end

  // Flags to be set this cycle
  always_comb begin
    set_flags = 16'h0000;
    set_flags[timer_pwm_pkg::FLAG_SHARED] = cmp_hit[4] | cap_hit[3];
    set_flags[timer_pwm_pkg::FLAG_CMP_LO +: 4] = cmp_hit[3:0];
    set_flags[timer_pwm_pkg::FLAG_CAP_LO +: 3] = cap_hit[2:0];
    set_flags[timer_pwm_pkg::FLAG_TOF] = main_tick && state.main_cnt == 16'hffff;
    set_flags[timer_pwm_pkg::FLAG_ACC_OV] = state.acc_ctl[14] && acc_tick && state.acc_ctl[7:0] == 8'hff;
    set_flags[timer_pwm_pkg::FLAG_ACC_IN] = state.acc_ctl[14] && (state.acc_ctl[13]
      ? (state.pin_prev[4] != state.acc_ctl[12]) && (pins[4] == state.acc_ctl[12]) : acc_edge);
  end

  assign wr_go = state.aw_done && state.w_done && !state.bvalid;

  // Main next-state logic
  always_comb begin
    logic [15:0] wv;
    logic [7:0]  wa;
    logic [15:0] clr;
    wv  = state.w_data[15:0];
    wa  = state.aw_addr;
    clr = 16'h0000;
    next_state = state;
    next_state.pin_prev    = pins;
    next_state.presc       = state.presc + 9'h001;
    next_state.main_tick_q = state.main_tick_q ^ main_tick;
    next_state.gate_cnt    = (state.gate_cnt == 10'(timer_pwm_pkg::ACC_GATE_DIV - 1)) ? 10'h000 : state.gate_cnt + 10'h001;
    if (main_tick) begin
      next_state.main_cnt = state.main_cnt + 16'h0001;
    end
    if (pwm_tick) begin
      next_state.pwm_cnt = state.pwm_cnt + 16'h0001;
    end
    if (state.acc_ctl[14] && acc_tick) begin
      next_state.acc_ctl[7:0] = state.acc_ctl[7:0] + 8'h01;
    end
    for (int i = 0; i < 5; i++) begin
      next_state.oc_out[i] = cmp_hit[i] ? oc_next(state.tctl, i, state.oc_out[i]) : state.oc_out[i];
    end
    // AXI4-Lite write side
    if (awvalid && !state.aw_done) begin
      next_state.aw_done = 1'b1;
      next_state.aw_addr = awaddr;
    end
    if (wvalid && !state.w_done) begin
      next_state.w_done = 1'b1;
      next_state.w_data = wdata;
    end
    if (wr_go) begin
      next_state.aw_done = 1'b0;
      next_state.w_done  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = mapped(wa) ? timer_pwm_pkg::RESP_OKAY : timer_pwm_pkg::RESP_SLVERR;
      if (mapped(wa)) begin // Unmapped words are answered, never stored
        case (wa)
          timer_pwm_pkg::ADDR_TIMER_CTRL: next_state.tctl = wv;
          timer_pwm_pkg::ADDR_ACC_CTRL:   next_state.acc_ctl = {1'b0, wv[14:0]};
          timer_pwm_pkg::ADDR_MASK:       next_state.mask = wv;
          timer_pwm_pkg::ADDR_FLAGS:      clr = wv & timer_pwm_pkg::FLAG_MASK;
          timer_pwm_pkg::ADDR_FORCE_PWM: begin
            next_state.pwm_control_register = {5'h00, wv[10:0]};
            for (int i = 0; i < 5; i++) begin
              next_state.oc_out[i] = wv[11+i] ? oc_next(state.tctl, i, state.oc_out[i]) : next_state.oc_out[i];
            end
          end
          timer_pwm_pkg::ADDR_DUTY: begin
            next_state.duty_a = wv[15:8];
            next_state.duty_b = wv[7:0];
          end
          default: begin
            for (int i = 0; i < 5; i++) begin
              if (wa == timer_pwm_pkg::ADDR_COMPARE0 + 8'(4 * i)) begin
                next_state.compare[16*i +: 16] = wv;
              end
            end
          end
        endcase
      end
    end
    if (state.bvalid && bready) begin
      next_state.bvalid = 1'b0;
    end
    // Flags: set beats a clear in the same cycle
    next_state.flags = (state.flags & ~clr) | set_flags;
    // AXI4-Lite read side
    if (arvalid && !state.rvalid) begin
      next_state.rvalid = 1'b1;
      next_state.rdata  = read_word(state, araddr, ch_a.duty_buf, ch_b.duty_buf);
      next_state.rresp  = mapped(araddr) ? timer_pwm_pkg::RESP_OKAY : timer_pwm_pkg::RESP_SLVERR;
    end else if (state.rvalid && rready) begin
      next_state.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state         <= '0;
      state.compare <= {5{timer_pwm_pkg::COMPARE_RESET}};
    end else begin
      state <= next_state;
    end
  end

  // Bus handshakes
  assign awready = !state.aw_done;
  assign wready  = !state.w_done;
  assign bvalid  = state.bvalid;
  assign bresp   = state.bresp;
  assign arready = !state.rvalid;
  assign rvalid  = state.rvalid;
  assign rdata   = state.rdata;
  assign rresp   = state.rresp;

  // Pin drive
  assign compare_pins      = state.oc_out;
  assign channel_a_pwm_pin = state.pwm_control_register[9] ? state.pwm_control_register[1]
                           : state.pwm_control_register[7] ? state.main_tick_q : ch_a.wave;
  assign channel_b_pwm_pin = state.pwm_control_register[8] ? state.pwm_control_register[0] : ch_b.wave;
  assign irq_src   = {state.mask[15:8], state.mask[7], 1'b0, state.mask[5:4], 4'h0};
  assign timer_irq = |(state.flags & irq_src);

  tof_wrap_a: assert property (@(posedge clock) disable iff (!nrst)
    main_tick && state.main_cnt == 16'hffff |=> state.flags[timer_pwm_pkg::FLAG_TOF]
    && state.main_cnt == 16'h0000) else $error("overflow flag missed");
  force_a_pin_a: assert property (@(posedge clock) disable iff (!nrst)
    state.pwm_control_register[9] |-> channel_a_pwm_pin == state.pwm_control_register[1]) else $error("force a ignored");
  force_b_pin_a: assert property (@(posedge clock) disable iff (!nrst)
    state.pwm_control_register[8] |-> channel_b_pwm_pin == state.pwm_control_register[0]) else $error("force b ignored");
  clock_out_a: assert property (@(posedge clock) disable iff (!nrst)
    !state.pwm_control_register[9] && state.pwm_control_register[7] |-> channel_a_pwm_pin == state.main_tick_q)
    else $error("clock output missing");
  presc_read_a: assert property (@(posedge clock) disable iff (!nrst)
    arvalid && arready && araddr == timer_pwm_pkg::ADDR_PRESCALER |=> rdata[31:9] == 23'h000000)
    else $error("prescaler high bits set");
  cmp_flag_a: assert property (@(posedge clock) disable iff (!nrst)
    cmp_hit[0] |=> state.flags[timer_pwm_pkg::FLAG_CMP_LO]) else $error("compare flag missed");
  pwm_step_a: assert property (@(posedge clock) disable iff (!nrst)
    pwm_tick |=> state.pwm_cnt == $past(state.pwm_cnt) + 16'h0001) else $error("pwm counter stuck");
  irq_out_a: assert property (@(posedge clock) disable iff (!nrst)
    (state.flags[timer_pwm_pkg::FLAG_ACC_IN] && state.mask[4]) |-> timer_irq) else $error("irq missing");
endmodule // timer_pwm_unit

//--- tb/pin_partner.sv
// External pin driver and PWM pin observer for the timer unit
`timescale 1ns/1ps
module pin_partner (
  input  wire logic  clock,
  input  wire logic  pwm_a,
  input  wire logic  pwm_b,
  output logic [3:0] capture_pins,
  output logic       acc_pin,
  output logic       ext_clock
);
  logic       ext_run;
  logic [2:0] div;

  // Idle pin levels
  initial begin
    capture_pins = 4'h0;
    acc_pin = 1'b0;
    ext_clock = 1'b0;
    ext_run = 1'b0;
    div = 3'h0;
  end

  // External clock toggles every 8 cycles, stands low when not running
  always @(posedge clock) begin
    div <= div + 3'h1;
    if (!ext_run) ext_clock <= 1'b0;
    else if (div == 3'h7) ext_clock <= ~ext_clock;
  end

  // Starts or stops the external clock
  task automatic set_ext(input logic on);
    @(posedge clock);
    ext_run <= on;
  endtask

  // Four-cycle high pulse, long enough for the two-flop synchroniser
  task automatic pulse(input int idx);
    @(posedge clock);
    if (idx < 4) capture_pins[idx] <= 1'b1;
    else acc_pin <= 1'b1;
    repeat (4) @(posedge clock);
    capture_pins <= 4'h0;
    acc_pin <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  // Counts high cycles on both PWM pins over a window of n cycles; an unknown level overflows the count
  task automatic measure(input int n, output int ha, output int hb);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(posedge clock);
      ha += $isunknown(pwm_a) ? n + 1 : int'(pwm_a);
      hb += $isunknown(pwm_b) ? n + 1 : int'(pwm_b);
    end
  endtask
endmodule // pin_partner

//--- tb/timer_pwm_unit_tb.sv
// Self-checking bench for the timer flag and PWM unit
`timescale 1ns/1ps
module timer_pwm_unit_tb;
  typedef struct packed { logic [15:0] ctrl; logic a; logic b; } force_row_t;
  logic        clock, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, acc_pin, ext_clock, pwm_a, pwm_b, timer_irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, bresp_seen, rresp_seen;
  logic [3:0]  wstrb, capture_pins;
  logic [4:0]  compare_pins;
  logic [15:0] c0, delta, expd;
  int          errors, checks, cycles, ha, hb;
  force_row_t  rows [5];

  timer_pwm_unit i_timer_pwm_unit (.clock(clock), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .capture_pins(capture_pins),
    .accumulator_input_pin(acc_pin), .ext_clock_pin(ext_clock), .compare_pins(compare_pins),
    .channel_a_pwm_pin(pwm_a), .channel_b_pwm_pin(pwm_b), .timer_irq(timer_irq));

  pin_partner i_pin_partner (.clock(clock), .pwm_a(pwm_a), .pwm_b(pwm_b), .capture_pins(capture_pins),
    .acc_pin(acc_pin), .ext_clock(ext_clock));

  // 10 MHz clock
  initial clock = 1'b0;
  always #50 clock = ~clock;

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      finish_test();
    end
  end

  // Verdict and end of run
  task automatic finish_test;
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Compares one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    bresp_seen = bresp;
  endtask

  // Bus read
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rd = rdata;
    rresp_seen = rresp;
  endtask

  initial begin
    {awvalid, wvalid, arvalid, nrst} = 4'h0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    {errors, checks, cycles} = {32'd0, 32'd0, 32'd0};
    rows[0] = {16'h0202, 1'b1, 1'b0};
    rows[1] = {16'h0281, 1'b0, 1'b0};
    rows[2] = {16'h0101, 1'b0, 1'b1};
    rows[3] = {16'h0302, 1'b1, 1'b0};
    rows[4] = {16'h0303, 1'b1, 1'b1};
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    // Reset values
    rdr(timer_pwm_pkg::ADDR_PRESCALER);
    check(rd & 32'hfffffe00, 32'h0);
    rdr(timer_pwm_pkg::ADDR_DUTY_BUF);
    check(rd, 32'h0);
    rdr(timer_pwm_pkg::ADDR_FLAGS);
    check(rd, 32'h0);
    // Forced pin levels, sampled twice so a running clock output would show
    foreach (rows[i]) begin
      wr(timer_pwm_pkg::ADDR_FORCE_PWM, 32'(rows[i].ctrl));
      repeat (2) @(posedge clock);
      check(32'({pwm_a, pwm_b}), 32'({rows[i].a, rows[i].b}));
      repeat (5) @(posedge clock);
      check(32'({pwm_a, pwm_b}), 32'({rows[i].a, rows[i].b}));
    end
    // Counter clock on pin A toggles; pin B idles low at zero duty
    wr(timer_pwm_pkg::ADDR_FORCE_PWM, 32'h0080);
    i_pin_partner.measure(32, ha, hb);
    check(32'(ha > 0 && ha < 32), 32'h1);
    check(32'(hb), 32'h0);
    // Duty fractions at divide-by-4, fast period of 1024 cycles
    wr(timer_pwm_pkg::ADDR_FORCE_PWM, 32'h0010);
    wr(timer_pwm_pkg::ADDR_DUTY, 32'h8000);
    repeat (2048) @(posedge clock);
    i_pin_partner.measure(1024, ha, hb);
    check(32'(ha), 32'd512);
    check(32'(hb), 32'd0);
    wr(timer_pwm_pkg::ADDR_DUTY, 32'hff80);
    rdr(timer_pwm_pkg::ADDR_DUTY_BUF);
    check(32'(rd[15:0]), 32'h8000);
    repeat (2048) @(posedge clock);
    i_pin_partner.measure(1024, ha, hb);
    check(32'(ha), 32'd1020);
    check(32'(hb), 32'd512);
    rdr(timer_pwm_pkg::ADDR_DUTY_BUF);
    check(32'(rd[15:0]), 32'hff80);
    // PWM counter rate for every prescaler code
    for (int code = 0; code < 8; code++) begin
      if (code == 7) i_pin_partner.set_ext(1'b1);
      wr(timer_pwm_pkg::ADDR_FORCE_PWM, 32'(code << 4) | 32'h4);
      rdr(timer_pwm_pkg::ADDR_PWM_COUNT);
      c0 = rd[15:0];
      repeat (256) @(posedge clock);
      rdr(timer_pwm_pkg::ADDR_PWM_COUNT);
      delta = rd[15:0] - c0;
      expd = (code == 7) ? 16'd16 : 16'(256 >> (code + 1));
      check(32'(delta + 16'd1 >= expd && delta <= expd + 16'd1), 32'h1);
    end
    i_pin_partner.set_ext(1'b0);
    rdr(timer_pwm_pkg::ADDR_PRESCALER);
    check(rd & 32'hfffffe00, 32'h0);
    // Compare 1 match a few counts ahead
    rdr(timer_pwm_pkg::ADDR_MAIN_COUNT);
    wr(timer_pwm_pkg::ADDR_COMPARE0, 32'(rd[15:0] + 16'd16));
    rd = 32'h0;
    for (int n = 0; n < 100 && rd[timer_pwm_pkg::FLAG_CMP_LO] !== 1'b1; n++) rdr(timer_pwm_pkg::ADDR_FLAGS);
    check(32'(rd[timer_pwm_pkg::FLAG_CMP_LO]), 32'h1);
    // Force compare 2 with set action: pin high, flag untouched
    wr(timer_pwm_pkg::ADDR_FLAGS, 32'hffff);
    wr(timer_pwm_pkg::ADDR_TIMER_CTRL, 32'h0341);
    wr(timer_pwm_pkg::ADDR_FORCE_PWM, 32'h1010);
    repeat (2) @(posedge clock);
    check(32'(compare_pins[1]), 32'h1);
    rdr(timer_pwm_pkg::ADDR_FLAGS);
    check(32'(rd[timer_pwm_pkg::FLAG_CMP_LO + 1]), 32'h0);
    // Clear action, then toggle action, on the same pin
    wr(timer_pwm_pkg::ADDR_TIMER_CTRL, 32'h0241);
    wr(timer_pwm_pkg::ADDR_FORCE_PWM, 32'h1010);
    repeat (2) @(posedge clock);
    check(32'(compare_pins[1]), 32'h0);
    wr(timer_pwm_pkg::ADDR_TIMER_CTRL, 32'h0141);
    wr(timer_pwm_pkg::ADDR_FORCE_PWM, 32'h1010);
    repeat (2) @(posedge clock);
    check(32'(compare_pins[1]), 32'h1);
    // Rising edges on capture 1, shared channel and an accumulator about to wrap
    wr(timer_pwm_pkg::ADDR_ACC_CTRL, 32'h54ff);
    i_pin_partner.pulse(0);
    i_pin_partner.pulse(3);
    i_pin_partner.pulse(4);
    rdr(timer_pwm_pkg::ADDR_FLAGS);
    check(32'({rd[15], rd[8], rd[5], rd[4]}), 32'hf);
    rdr(timer_pwm_pkg::ADDR_ACC_CTRL);
    check(32'(rd[7:0]), 32'h0);
    // Interrupt request follows an enabled flag and drops when it is cleared
    wr(timer_pwm_pkg::ADDR_MASK, 32'h0010);
    repeat (2) @(posedge clock);
    check(32'(timer_irq), 32'h1);
    wr(timer_pwm_pkg::ADDR_FLAGS, 32'hffff);
    repeat (2) @(posedge clock);
    check(32'(timer_irq), 32'h0);
    // Gated accumulation: input flag marks the end of the high period
    wr(timer_pwm_pkg::ADDR_ACC_CTRL, 32'h6000);
    i_pin_partner.pulse(4);
    rdr(timer_pwm_pkg::ADDR_FLAGS);
    check(32'(rd[timer_pwm_pkg::FLAG_ACC_IN]), 32'h1);
    // Unmapped read and a write to a read-only word
    rdr(8'hfc);
    check(32'(rresp_seen), 32'(timer_pwm_pkg::RESP_SLVERR));
    wr(timer_pwm_pkg::ADDR_PWM_COUNT, 32'h1);
    check(32'(bresp_seen), 32'(timer_pwm_pkg::RESP_OKAY));
    // Reset in mid-run clears buffers and control
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rdr(timer_pwm_pkg::ADDR_DUTY_BUF);
    check(rd, 32'h0);
    rdr(timer_pwm_pkg::ADDR_FORCE_PWM);
    check(rd, 32'h0);
    finish_test();
  end
endmodule // timer_pwm_unit_tb
